/* edc_assertions.sv */
// Purpose: port checks of the dma channel controller
// Assumes: one clock, reset active high
// Notes: engine ports and apb decode
`timescale 1ns/100ps
module edc_assertions #(
  parameter int NUM_ENG = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [15:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input edc_pkg::edc_mem_req_t mem_req [NUM_ENG],
  input edc_pkg::edc_mem_rsp_t mem_rsp [NUM_ENG],
  input wire logic done_irq
);
  import edc_pkg::*;
  // ****
  // checks
  // ****
  wire acc = psel && penable;
  wire rd_take = mem_req[0].valid && !mem_req[0].write && mem_rsp[0].ready;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_irq_rst: assert property ($fell(rst) |-> !done_irq)
    else $error("irq after reset");
  a_req_rst: assert property ($fell(rst) |-> !mem_req[0].valid && !mem_req[1].valid)
    else $error("request after reset");
  a_hold_e0: assert property (mem_req[0].valid && !mem_rsp[0].ready |=> $stable(mem_req[0]))
    else $error("engine 0 request moved");
  a_hold_e1: assert property (mem_req[1].valid && !mem_rsp[1].ready |=> $stable(mem_req[1]))
    else $error("engine 1 request moved");
  a_one_read: assert property (rd_take |=> !mem_req[0].valid)
    else $error("second read");
  a_unmapped: assert property (acc && paddr == 16'h5000 |-> pslverr)
    else $error("no error past sets");
  a_pmem_ok: assert property (acc && paddr[15:12] == 4'h4 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("set write refused");
  a_no_wait: assert property (acc |-> pready)
    else $error("wait state");
  c_read: cover property (rd_take);
  c_done: cover property ($rose(done_irq));
  c_err: cover property (acc && pslverr);
endmodule // edc_assertions

bind edc_channel_ctrl edc_assertions #(.NUM_ENG(NUM_ENG)) edc_assertions_inst (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_rsp(mem_rsp),
  .done_irq(done_irq));

/* edc_cfg.svh */
// Purpose: constants of the event dma channel controller and transfer engines
// Assumes: apb byte addresses on a 16-bit window
// Notes: parameter set words are 32 bits, eight per set
`ifndef EDC_CFG_SVH
`define EDC_CFG_SVH

// ********************************************************
// sizes
// ********************************************************
`define EDC_NUM_QUICK 8
`define EDC_NUM_SETS 128
`define EDC_Q_DEPTH 16
`define EDC_NUM_ENG 2
`define EDC_MAX_OUT 4
`define EDC_BEAT_BYTES 32'd8

// ********************************************************
// register byte offsets
// ********************************************************
`define EDC_OFF_PEND_LO 16'h0000
`define EDC_OFF_PEND_HI 16'h0004
`define EDC_OFF_EN_LO 16'h0008
`define EDC_OFF_EN_HI 16'h000c
`define EDC_OFF_SET_LO 16'h0010
`define EDC_OFF_SET_HI 16'h0014
`define EDC_OFF_DONE_LO 16'h0018
`define EDC_OFF_DONE_HI 16'h001c
`define EDC_OFF_ERR 16'h0020
`define EDC_OFF_QPRI 16'h0024
`define EDC_OFF_QSTAT 16'h0028
`define EDC_OFF_QPTR 16'h0040
`define EDC_OFF_PMEM 16'h4000

// ********************************************************
// parameter set words and option bits
// ********************************************************
`define EDC_W_OPT 3'h0
`define EDC_W_SRC 3'h1
`define EDC_W_CNT 3'h2
`define EDC_W_DST 3'h3
`define EDC_W_BIDX 3'h4
`define EDC_W_LINK 3'h5
`define EDC_W_CIDX 3'h6
`define EDC_W_CCNT 3'h7
`define EDC_TRIG_WORD 3'h7
`define EDC_OPT_SAM 0
`define EDC_OPT_DAM 1
`define EDC_OPT_AB 2
`define EDC_OPT_CHAIN 3
`define EDC_OPT_DONE 4
`define EDC_OPT_QUE 5
`define EDC_OPT_TCC 8
`define EDC_LINK_NULL 16'hffff
`define EDC_QPTR_EN 7

// ********************************************************
// error bits and reset values
// ********************************************************
`define EDC_ERR_MISS 0
`define EDC_ERR_NULL 1
`define EDC_ERR_ENG 2
`define EDC_QPRI_RST 6'h08
`define EDC_QPTR_RST 8'h00

`endif

/* edc_channel_ctrl.sv */
// Purpose: channel controller, event queues and transfer engines of a dma
// Assumes: apb slave with zero wait states, events are one-cycle pulses
// Notes: parameter memory is flop based and written by apb before updates
//
// What this block does
// - sixty-four event channels plus eight quick channels started by parameter writes
// - parameter memory of 128 sets, eight 32-bit words each
// - sets 0-63 serve the event channel of the same number; any set serves quick channel or link reload
// - event channel starts on hardware event, software set, or chain
// - hardware events recorded as pending even when channel disabled
// - each channel except 8, 9, 12 and 13 has one fixed, non-remappable event source; 12 and 13 have none
// - channels 0-7 take timer3, audio port 0 and video events
// - channels 8 and 9 take audio port 1 or timer2 events
// - channels 18-21 take uart0 and uart1 receive and transmit
// - quick channel submits at once when its trigger word is written
// - each quick channel has a programmable parameter set pointer
// - parameter memory accepts writes from any configuration bus master
// - A-sync serves one dimension, AB-sync two; independent indexes
// - source and destination support incrementing and constant addressing
// - exhausted set reloads from the linked set
// - completion with chaining enabled triggers the designated channel
// - two sixteen-entry event queues with software-set relative priority
// - engines use 64-bit ports and at most four outstanding requests
// - engines do two dimensions; controller sequences the third
// - completion and error raise interrupts and are recorded
// - engines reach all memories and configuration registers
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
`include "edc_cfg.svh"

module edc_channel_ctrl #(
  parameter int NUM_QUICK = `EDC_NUM_QUICK,
  parameter int NUM_SETS = `EDC_NUM_SETS,
  parameter int Q_DEPTH = `EDC_Q_DEPTH,
  parameter int NUM_ENG = `EDC_NUM_ENG,
  parameter int MAX_OUT = `EDC_MAX_OUT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input edc_pkg::edc_evt_src_t evt_src,
  input wire logic [1:0] event_source_select,
  input wire logic [41:0] upper_events,
  output edc_pkg::edc_mem_req_t mem_req [NUM_ENG],
  input edc_pkg::edc_mem_rsp_t mem_rsp [NUM_ENG],
  output logic done_irq,
  output logic error_irq
);
  import edc_pkg::*;

  localparam int SW = $clog2(NUM_SETS);
  localparam int PW = SW + 3;
  localparam int QW = $clog2(Q_DEPTH);
  localparam int OW = $clog2(MAX_OUT) + 1;
  localparam int EW = 2 + NUM_ENG;

  // ********************************************************
  // state
  // ********************************************************
  logic [31:0] pmem [NUM_SETS * 8];
  logic [63:0] pend, en, done;
  logic [EW-1:0] err;
  logic [NUM_QUICK-1:0] quick_pend;
  logic [7:0] qptr [NUM_QUICK];
  logic [3*NUM_ENG-1:0] qpri;
  wire [NUM_ENG-1:0] q_full, push, eng_done, eng_err;
  wire [31:0] eng_opt [NUM_ENG];
  wire [QW:0] q_cnt [NUM_ENG];

  // ********************************************************
  // apb decode
  // ********************************************************
  wire [15:0] pmem_base = `EDC_OFF_PMEM;
  wire [15:0] qptr_base = `EDC_OFF_QPTR;
  wire [15:0] pm_off = paddr - pmem_base;
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire hit_pend_lo = paddr == `EDC_OFF_PEND_LO;
  wire hit_pend_hi = paddr == `EDC_OFF_PEND_HI;
  wire hit_en_lo = paddr == `EDC_OFF_EN_LO;
  wire hit_en_hi = paddr == `EDC_OFF_EN_HI;
  wire hit_set_lo = paddr == `EDC_OFF_SET_LO;
  wire hit_set_hi = paddr == `EDC_OFF_SET_HI;
  wire hit_done_lo = paddr == `EDC_OFF_DONE_LO;
  wire hit_done_hi = paddr == `EDC_OFF_DONE_HI;
  wire hit_err = paddr == `EDC_OFF_ERR;
  wire hit_qpri = paddr == `EDC_OFF_QPRI;
  wire hit_qstat = paddr == `EDC_OFF_QSTAT;
  wire hit_qptr = paddr[15:5] == qptr_base[15:5] && paddr[1:0] == 2'h0;
  wire hit_pmem = paddr >= pmem_base && pm_off < 16'(NUM_SETS * 32) && paddr[1:0] == 2'h0;
  wire [PW-1:0] pm_idx = pm_off[PW+1:2];
  wire mapped = hit_pend_lo | hit_pend_hi | hit_en_lo | hit_en_hi | hit_set_lo | hit_set_hi |
    hit_done_lo | hit_done_hi | hit_err | hit_qpri | hit_qstat | hit_qptr | hit_pmem;
  // any bus master may write sets
  wire pm_wr = wr & hit_pmem;
  wire [63:0] w1c_pend = {wr & hit_pend_hi ? pwdata : 32'h0, wr & hit_pend_lo ? pwdata : 32'h0};
  wire [63:0] w1c_done = {wr & hit_done_hi ? pwdata : 32'h0, wr & hit_done_lo ? pwdata : 32'h0};
  wire [63:0] sw_set = {wr & hit_set_hi ? pwdata : 32'h0, wr & hit_set_lo ? pwdata : 32'h0};
  wire [EW-1:0] w1c_err = wr & hit_err ? pwdata[EW-1:0] : '0;

  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // ********************************************************
  // fixed event map
  // ********************************************************
  wire [63:0] hw_evt;
  assign hw_evt[0] = evt_src.timer3_irq_a;
  assign hw_evt[1] = evt_src.timer3_irq_b;
  assign hw_evt[2] = evt_src.audio0_tx_request;
  assign hw_evt[3] = evt_src.audio0_rx_request;
  assign hw_evt[7:4] = evt_src.video_subsystem_evt;
  assign hw_evt[8] = event_source_select[0] ? evt_src.timer2_irq_a : evt_src.audio1_tx_request;
  assign hw_evt[9] = event_source_select[1] ? evt_src.timer2_irq_b : evt_src.audio1_rx_request;
  assign hw_evt[10] = evt_src.serial_port2_tx_request;
  assign hw_evt[11] = evt_src.serial_port2_rx_request;
  assign hw_evt[13:12] = 2'h0;
  assign hw_evt[14] = evt_src.serial_port1_tx_request;
  assign hw_evt[15] = evt_src.serial_port1_rx_request;
  assign hw_evt[16] = evt_src.serial_port0_tx_request;
  assign hw_evt[17] = evt_src.serial_port0_rx_request;
  assign hw_evt[18] = evt_src.uart0_rx_request;
  assign hw_evt[19] = evt_src.uart0_tx_request;
  assign hw_evt[20] = evt_src.uart1_rx_request;
  assign hw_evt[21] = evt_src.uart1_tx_request;
  assign hw_evt[63:22] = upper_events;

  // ********************************************************
  // quick channel triggers
  // ********************************************************
  wire [NUM_QUICK-1:0] qtrig;
  for (genvar i = 0; i < NUM_QUICK; i++) begin : g_qtrig
    assign qtrig[i] = pm_wr & qptr[i][`EDC_QPTR_EN] & pm_idx[PW-1:3] == qptr[i][SW-1:0] &
      pm_idx[2:0] == `EDC_TRIG_WORD;
  end

  // ********************************************************
  // arbitration and set update
  // ********************************************************
  // pending waits for enable
  wire [63:0] ready_ch = pend & en;
  logic [5:0] sel_ch;
  logic [$clog2(NUM_QUICK)-1:0] sel_q;
  always_comb begin
    sel_ch = '0;
    sel_q = '0;
    for (int i = 63; i >= 0; i--) begin
      if (ready_ch[i]) sel_ch = 6'(i);
    end
    for (int i = NUM_QUICK - 1; i >= 0; i--) begin
      if (quick_pend[i]) sel_q = ($clog2(NUM_QUICK))'(i);
    end
  end
  wire sel_is_evt = |ready_ch;
  wire sel_any = sel_is_evt | (|quick_pend);
  wire [SW-1:0] sel_set = sel_is_evt ? SW'(sel_ch) : qptr[sel_q][SW-1:0];
  wire [31:0] s_opt = pmem[{sel_set, `EDC_W_OPT}];
  wire [31:0] s_src = pmem[{sel_set, `EDC_W_SRC}];
  wire [31:0] s_cnt = pmem[{sel_set, `EDC_W_CNT}];
  wire [31:0] s_dst = pmem[{sel_set, `EDC_W_DST}];
  wire [31:0] s_bidx = pmem[{sel_set, `EDC_W_BIDX}];
  wire [31:0] s_link = pmem[{sel_set, `EDC_W_LINK}];
  wire [31:0] s_cidx = pmem[{sel_set, `EDC_W_CIDX}];
  wire [15:0] cur_b = s_cnt[31:16];
  wire [15:0] cur_c = pmem[{sel_set, `EDC_W_CCNT}][15:0];
  wire ab = s_opt[`EDC_OPT_AB];
  wire [0:0] tq = s_opt[`EDC_OPT_QUE];
  wire null_set = cur_c == 16'h0;
  wire go = sel_any & ~pm_wr & (null_set | ~q_full[tq]);
  wire upd = go & ~null_set;
  wire c_step = ab | cur_b == 16'h1;
  wire exhaust = c_step & cur_c == 16'h1;
  wire do_link = exhaust & s_link[15:0] != `EDC_LINK_NULL;
  wire [SW-1:0] link_set = s_link[SW-1:0];
  wire [15:0] s_step = c_step ? s_cidx[15:0] : s_bidx[15:0];
  wire [15:0] d_step = c_step ? s_cidx[31:16] : s_bidx[31:16];
  wire [31:0] new_src = s_opt[`EDC_OPT_SAM] ? s_src : s_src + {{16{s_step[15]}}, s_step};
  wire [31:0] new_dst = s_opt[`EDC_OPT_DAM] ? s_dst : s_dst + {{16{d_step[15]}}, d_step};
  wire [15:0] new_b = ab ? cur_b : (cur_b == 16'h1 ? s_link[31:16] : cur_b - 16'h1);
  wire [15:0] new_c = c_step ? cur_c - 16'h1 : cur_c;
  edc_xfer_t new_xfer;
  // one or two dimensions per event
  assign new_xfer = '{src: s_src, dst: s_dst, acnt: s_cnt[15:0], bcnt: ab ? cur_b : 16'h1,
    sbidx: s_bidx[15:0], dbidx: s_bidx[31:16], opt: s_opt};
  for (genvar e = 0; e < NUM_ENG; e++) begin : g_push
    assign push[e] = upd & tq == e;
  end

  always_ff @(posedge core_clk) begin
    if (pm_wr) begin
      pmem[pm_idx] <= pwdata;
    end else if (upd & do_link) begin
      for (int w = 0; w < 8; w++) begin
        pmem[{sel_set, 3'(w)}] <= pmem[{link_set, 3'(w)}];
      end
    end else if (upd) begin
      pmem[{sel_set, `EDC_W_SRC}] <= new_src;
      pmem[{sel_set, `EDC_W_DST}] <= new_dst;
      pmem[{sel_set, `EDC_W_CNT}] <= {new_b, s_cnt[15:0]};
      pmem[{sel_set, `EDC_W_CCNT}] <= {16'h0, new_c};
    end
  end

  // ********************************************************
  // completion, chaining and status
  // ********************************************************
  logic [63:0] chain_set, done_set;
  always_comb begin
    chain_set = '0;
    done_set = '0;
    for (int e = 0; e < NUM_ENG; e++) begin
      if (eng_done[e] & eng_opt[e][`EDC_OPT_CHAIN]) chain_set[eng_opt[e][`EDC_OPT_TCC +: 6]] = 1'b1;
      if (eng_done[e] & eng_opt[e][`EDC_OPT_DONE]) done_set[eng_opt[e][`EDC_OPT_TCC +: 6]] = 1'b1;
    end
  end
  wire [63:0] clr_evt = go & sel_is_evt ? 64'h1 << sel_ch : 64'h0;
  wire [NUM_QUICK-1:0] clr_q = go & ~sel_is_evt ? NUM_QUICK'(1) << sel_q : '0;
  wire missed = |(hw_evt & pend) | (|(qtrig & quick_pend));
  wire [EW-1:0] err_set = {eng_err, go & null_set, missed};
  wire [63:0] next_pend = (pend & ~w1c_pend & ~clr_evt) | hw_evt | sw_set | chain_set;
  wire [NUM_QUICK-1:0] next_quick_pend = (quick_pend & ~clr_q) | qtrig;
  wire [63:0] next_done = (done & ~w1c_done) | done_set;
  wire [EW-1:0] next_err = (err & ~w1c_err) | err_set;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend <= '0;
      en <= '0;
      done <= '0;
      err <= '0;
      quick_pend <= '0;
      qpri <= (3*NUM_ENG)'(`EDC_QPRI_RST);
      done_irq <= 1'b0;
      error_irq <= 1'b0;
      for (int i = 0; i < NUM_QUICK; i++) begin
        qptr[i] <= `EDC_QPTR_RST;
      end
    end else begin
      pend <= next_pend;
      quick_pend <= next_quick_pend;
      done <= next_done;
      err <= next_err;
      done_irq <= |next_done;
      error_irq <= |next_err;
      if (wr & hit_en_lo) en[31:0] <= pwdata;
      if (wr & hit_en_hi) en[63:32] <= pwdata;
      if (wr & hit_qpri) qpri <= pwdata[3*NUM_ENG-1:0];
      for (int i = 0; i < NUM_QUICK; i++) begin
        if (wr & hit_qptr & paddr[4:2] == 3'(i)) qptr[i] <= pwdata[7:0];
      end
    end
  end

  // ********************************************************
  // apb read data
  // ********************************************************
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0;
    if (hit_pend_lo) next_prdata = pend[31:0];
    else if (hit_pend_hi) next_prdata = pend[63:32];
    else if (hit_en_lo) next_prdata = en[31:0];
    else if (hit_en_hi) next_prdata = en[63:32];
    else if (hit_done_lo) next_prdata = done[31:0];
    else if (hit_done_hi) next_prdata = done[63:32];
    else if (hit_err) next_prdata = 32'(err);
    else if (hit_qpri) next_prdata = 32'(qpri);
    else if (hit_qptr) next_prdata = {24'h0, qptr[paddr[4:2]]};
    else if (hit_pmem) next_prdata = pmem[pm_idx];
    else if (hit_qstat) begin
      for (int e = 0; e < NUM_ENG; e++) begin
        next_prdata[e*8 +: QW+1] = q_cnt[e];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) prdata <= 32'h0;
    else if (psel & ~penable) prdata <= next_prdata;
  end

  // ********************************************************
  // event queues and transfer engines
  // ********************************************************
  for (genvar e = 0; e < NUM_ENG; e++) begin : g_eng
    edc_xfer_t qmem [Q_DEPTH];
    edc_xfer_t xfer;
    edc_eng_state_t st;
    edc_mem_req_t req;
    logic [QW-1:0] wp, rp;
    logic [QW:0] cnt;
    logic [15:0] a_left, b_left;
    logic [31:0] src_a, dst_a, src_p, dst_p;
    logic [63:0] rbuf;
    logic [OW-1:0] wout;
    logic done_r, err_r;
    wire pop = st == ENG_IDLE && cnt != '0;
    wire taken = req.valid & mem_rsp[e].ready;
    wire [OW-1:0] next_wout = wout + OW'(taken & req.write) - OW'(mem_rsp[e].wack);
    wire [31:0] nsrc = xfer.opt[`EDC_OPT_SAM] ? src_p : src_p + `EDC_BEAT_BYTES;
    wire [31:0] ndst = xfer.opt[`EDC_OPT_DAM] ? dst_p : dst_p + `EDC_BEAT_BYTES;
    wire [31:0] asrc = xfer.opt[`EDC_OPT_SAM] ? src_a : src_a + {{16{xfer.sbidx[15]}}, xfer.sbidx};
    wire [31:0] adst = xfer.opt[`EDC_OPT_DAM] ? dst_a : dst_a + {{16{xfer.dbidx[15]}}, xfer.dbidx};

    assign q_full[e] = cnt == (QW+1)'(Q_DEPTH);
    assign q_cnt[e] = cnt;
    assign eng_done[e] = done_r;
    assign eng_err[e] = err_r;
    assign eng_opt[e] = xfer.opt;
    assign mem_req[e] = req;

    always_ff @(posedge core_clk) begin
      if (push[e]) qmem[wp] <= new_xfer;
    end

    always_ff @(posedge core_clk) begin
      if (rst) begin
        wp <= '0;
        rp <= '0;
        cnt <= '0;
      end else begin
        wp <= wp + QW'(push[e]);
        rp <= rp + QW'(pop);
        cnt <= cnt + (QW+1)'(push[e]) - (QW+1)'(pop);
      end
    end

    always_ff @(posedge core_clk) begin
      if (rst) begin
        st <= ENG_IDLE;
        req <= '0;
        xfer <= '0;
        a_left <= '0;
        b_left <= '0;
        src_a <= '0;
        dst_a <= '0;
        src_p <= '0;
        dst_p <= '0;
        rbuf <= '0;
        wout <= '0;
        done_r <= 1'b0;
        err_r <= 1'b0;
      end else begin
        done_r <= 1'b0;
        err_r <= mem_rsp[e].err;
        wout <= next_wout;
        req.pri <= qpri[3*e +: 3];
        unique case (st)
          ENG_IDLE: begin
            if (pop) begin
              xfer <= qmem[rp];
              a_left <= qmem[rp].acnt;
              b_left <= qmem[rp].bcnt;
              src_a <= qmem[rp].src;
              dst_a <= qmem[rp].dst;
              src_p <= qmem[rp].src;
              dst_p <= qmem[rp].dst;
              if (qmem[rp].acnt == 16'h0 || qmem[rp].bcnt == 16'h0) begin
                st <= ENG_DRAIN;
              end else begin
                req.valid <= 1'b1;
                req.write <= 1'b0;
                req.addr <= qmem[rp].src;
                st <= ENG_RD;
              end
            end
          end
          ENG_RD: begin
            if (taken) begin
              req.valid <= 1'b0;
              st <= ENG_RWAIT;
            end
          end
          ENG_RWAIT: begin
            if (mem_rsp[e].rvalid) begin
              rbuf <= mem_rsp[e].rdata;
              st <= ENG_WR;
            end
          end
          ENG_WR: begin
            if (!req.valid && wout < OW'(MAX_OUT - 1)) begin
              req.valid <= 1'b1;
              req.write <= 1'b1;
              req.addr <= dst_p;
              req.wdata <= rbuf;
            end else if (taken) begin
              req.write <= 1'b0;
              if (a_left > 16'h1) begin
                a_left <= a_left - 16'h1;
                src_p <= nsrc;
                dst_p <= ndst;
                req.addr <= nsrc;
                st <= ENG_RD;
              end else if (b_left > 16'h1) begin
                b_left <= b_left - 16'h1;
                a_left <= xfer.acnt;
                src_a <= asrc;
                dst_a <= adst;
                src_p <= asrc;
                dst_p <= adst;
                req.addr <= asrc;
                st <= ENG_RD;
              end else begin
                req.valid <= 1'b0;
                st <= ENG_DRAIN;
              end
            end
          end
          ENG_DRAIN: begin
            if (next_wout == '0) begin
              done_r <= 1'b1;
              st <= ENG_IDLE;
            end
          end
        endcase
      end
    end
  end

endmodule // edc_channel_ctrl

/* edc_mem_model.sv */
// Purpose: memory behind one transfer engine
// Assumes: one clock
// Notes: slow stalls every other cycle
`timescale 1ns/100ps
module edc_mem_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic slow,
  input edc_pkg::edc_mem_req_t req,
  output edc_pkg::edc_mem_rsp_t rsp,
  output logic [95:0] last_wr,
  output logic [7:0] wr_count
);
  import edc_pkg::*;
  // ****
  // responder
  // ****
  logic stall, rv, wk;
  logic [63:0] rd;
  wire take = req.valid && !stall;
  assign rsp = '{take, rv, rd, wk, 1'b0};
  always_ff @(posedge core_clk) begin
    stall <= !rst && slow && !stall;
    rv <= !rst && take && !req.write;
    wk <= !rst && take && req.write;
    rd <= (take && !req.write) ? {req.addr, ~req.addr} : ~rd;
    wr_count <= rst ? 8'h0 : wr_count + 8'(take && req.write);
    if (take && req.write)
      last_wr <= {req.addr, req.wdata};
  end
endmodule // edc_mem_model

/* edc_pkg.sv */
// Purpose: types of the event dma channel controller
// Assumes: nothing beyond the config header
// Notes: memory ports carry 64-bit data
package edc_pkg;

  // ********************************************************
  // transfer request
  // ********************************************************
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] acnt;
    logic [15:0] bcnt;
    logic [15:0] sbidx;
    logic [15:0] dbidx;
    logic [31:0] opt;
  } edc_xfer_t;

  // ********************************************************
  // memory master port
  // ********************************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [63:0] wdata;
    logic [2:0] pri;
  } edc_mem_req_t;

  typedef struct packed {
    logic ready;
    logic rvalid;
    logic [63:0] rdata;
    logic wack;
    logic err;
  } edc_mem_rsp_t;

  // ********************************************************
  // fixed peripheral event sources
  // ********************************************************
  typedef struct packed {
    logic timer3_irq_a;
    logic timer3_irq_b;
    logic audio0_tx_request;
    logic audio0_rx_request;
    logic [3:0] video_subsystem_evt;
    logic audio1_tx_request;
    logic audio1_rx_request;
    logic timer2_irq_a;
    logic timer2_irq_b;
    logic serial_port2_tx_request;
    logic serial_port2_rx_request;
    logic serial_port1_tx_request;
    logic serial_port1_rx_request;
    logic serial_port0_tx_request;
    logic serial_port0_rx_request;
    logic uart0_rx_request;
    logic uart0_tx_request;
    logic uart1_rx_request;
    logic uart1_tx_request;
  } edc_evt_src_t;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'b000,
    ENG_RD = 3'b001,
    ENG_RWAIT = 3'b010,
    ENG_WR = 3'b011,
    ENG_DRAIN = 3'b100
  } edc_eng_state_t;

endpackage

/* tb_edc_channel_ctrl.sv */
// Purpose: bench of the dma channel controller
// Assumes: zero wait apb
// Notes: memories are models
`timescale 1ns/100ps
`include "edc_cfg.svh"
module tb_edc_channel_ctrl;
  import edc_pkg::*;
  // ****
  // bench
  // ****
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic pready, pslverr, slverr, done_irq, error_irq;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, ps [8];
  logic [1:0] sel = 0;
  edc_evt_src_t evt = '0;
  edc_mem_req_t mem_req [2];
  edc_mem_rsp_t mem_rsp [2];
  logic [95:0] lw [2];
  logic [7:0] wn [2];
  int fails = 0, checked = 0, cyc = 0;
  always #20 core_clk = ~core_clk;
  edc_channel_ctrl edc_channel_ctrl_inst (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt_src(evt), .event_source_select(sel),
    .upper_events(42'h0), .mem_req(mem_req), .mem_rsp(mem_rsp), .done_irq(done_irq),
    .error_irq(error_irq));
  for (genvar e = 0; e < 2; e++) begin : g_mem
    edc_mem_model edc_mem_model_inst (.core_clk(core_clk), .rst(rst), .slow(slow),
      .req(mem_req[e]), .rsp(mem_rsp[e]), .last_wr(lw[e]), .wr_count(wn[e]));
  end
  task automatic stop_test();
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end
  task automatic check(string n, logic [127:0] got, logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic apb(logic w, logic [15:0] a, logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    slverr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic pulse(logic [21:0] v);
    @(posedge core_clk);
    evt <= v;
    @(posedge core_clk);
    evt <= '0;
  endtask
  task automatic wset(int s);
    for (int i = 0; i < 8; i++) apb(1, `EDC_OFF_PMEM + 16'(32 * s + 4 * i), ps[i]);
  endtask
  function automatic logic [31:0] exp_pend(int k, int s);
    int ch [22] = '{21, 20, 19, 18, 17, 16, 15, 14, 11, 10, 9, 8, 9, 8, 4, 5, 6, 7, 3, 2, 1, 0};
    return (k inside {[10:13]} && (k < 12) != (s == 1)) ? 0 : 32'h1 << ch[k];
  endfunction
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 0;
    apb(0, `EDC_OFF_QPRI, 0);
    check("qpri", rd, 32'h8);
    apb(0, 16'h5000, 0);
    check("unmapped", {slverr, rd}, 33'h1_0000_0000);
    for (int s = 0; s < 2; s++) begin
      sel <= 2'(3 * s);
      for (int k = 0; k < 22; k++) begin
        pulse(22'h1 << k);
        apb(0, `EDC_OFF_PEND_LO, 0);
        check("pend", rd, exp_pend(k, s));
        apb(1, `EDC_OFF_PEND_LO, 32'hffff_ffff);
      end
    end
    pulse(22'h1);
    pulse(22'h1);
    apb(0, `EDC_OFF_ERR, 0);
    check("missed", {error_irq, rd}, 33'h1_0000_0001);
    apb(1, `EDC_OFF_ERR, 32'h1);
    apb(1, `EDC_OFF_PEND_LO, 32'hffff_ffff);
    ps = '{32'h212, 32'h100, 32'h1_0002, 32'h200, 0, 32'h1_ffff, 0, 32'h1};
    wset(2);
    slow <= 1;
    pulse(22'h1 << 19);
    apb(0, `EDC_OFF_PEND_LO, 0);
    check("held", {wn[0], rd}, 40'h4);
    apb(1, `EDC_OFF_EN_LO, 32'h4);
    while (done_irq !== 1'b1) @(posedge core_clk);
    check("const", {wn[0], lw[0]}, {8'h2, 32'h200, 32'h108, ~32'h108});
    apb(0, `EDC_OFF_DONE_LO, 0);
    check("done", {error_irq, rd}, 33'h4);
    apb(1, `EDC_OFF_SET_LO, 32'h4);
    apb(0, `EDC_OFF_ERR, 0);
    check("null", {error_irq, rd}, 33'h1_0000_0002);
    slow <= 0;
    apb(1, `EDC_OFF_QPTR, 32'hc0);
    ps = '{32'h24, 32'h300, 32'h2_0001, 32'h400, 32'h10_0008, 32'h2_ffff, 0, 32'h1};
    wset(64);
    while (wn[1] !== 8'h2) @(posedge core_clk);
    check("quick", {lw[1], mem_req[1].pri}, {32'h410, 32'h308, ~32'h308, 3'h1});
    stop_test();
  end
endmodule // tb_edc_channel_ctrl
